/* src/ssr_cfg.svh */
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH
// Line length of one register line
`define SSR_LINE_BITS 100
// Shift clock source is the system clock
`define SSR_SYS_CLK_HZ 10000000
// Minimum circulation rate in Hz
`define SSR_MIN_RATE_HZ 1000
// Maximum data rate in Hz
`define SSR_MAX_RATE_HZ 1000000
// Longest idle gap between shifts, cycles (rounded down)
`define SSR_MAX_GAP_CYC (`SSR_SYS_CLK_HZ / `SSR_MIN_RATE_HZ)
// Least spacing between shifts, cycles (rounded up)
`define SSR_MIN_GAP_CYC \
	((`SSR_SYS_CLK_HZ + `SSR_MAX_RATE_HZ - 1) / `SSR_MAX_RATE_HZ)
// Cycles taken by phase two, the dead cycle and phase one
`define SSR_PHASE_CYC 3
`endif

/* src/ssr_pkg.sv */
package ssr_pkg;
	typedef enum logic [3:0] {
		SSR_IDLE = 4'h1,
		SSR_PH2 = 4'h2,
		SSR_GAP = 4'h4,
		SSR_PH1 = 4'h8
	} ssr_state_t;
endpackage : ssr_pkg

/* src/ssr_if.sv */
`timescale 1ns/1ps
interface ssr_if;
	logic phase1;
	logic phase2;
	logic data_in;
	logic recirc;
	logic data_out;
	modport dev (
		input phase1,
		input phase2,
		input data_in,
		input recirc,
		output data_out
	);
	modport ctl (
		output phase1,
		output phase2,
		output data_in,
		output recirc,
		input data_out
	);
endinterface : ssr_if

/* src/ssr_ctl.sv */
`timescale 1ns/1ps
`include "ssr_cfg.svh"
// Functional notes
// - Stage captures in phase two, passes in one
// - Output updated in phase one, valid in two
// - Input bit held through whole phase two
// - Keep shifting at or above minimum rate
// - Inverting input and output keep polarity
// - Written bit returns after line-length shifts
// - Access strictly serial, every position clocked
// - Position counter compared to address for access
// - Recirculate continuously in step with scan
// - Never shift faster than maximum data rate
module ssr_ctl
	import ssr_pkg::*;
#(
	parameter int LINE_BITS = `SSR_LINE_BITS,
	parameter int MAX_GAP = `SSR_MAX_GAP_CYC,
	parameter int MIN_GAP = `SSR_MIN_GAP_CYC
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// User request
	input wire logic i_req,
	input wire logic i_wr,
	input wire logic [$clog2(LINE_BITS)-1:0] i_addr,
	input wire logic i_wdata,
	output logic o_busy,
	output logic o_done,
	output logic o_rdata,
	output logic [$clog2(LINE_BITS)-1:0] o_pos,
	// Link
	ssr_if.ctl link
);
	localparam int AW = $clog2(LINE_BITS);
	localparam int CW = $clog2(MAX_GAP + 1);
	// Idle count at which the phase pulses start
	localparam int IDLE_END = MIN_GAP - `SSR_PHASE_CYC;

	// Sequencer
	ssr_state_t state_ff;
	ssr_state_t nxt_state;
	logic [CW-1:0] gap_ff;
	logic [CW-1:0] nxt_gap;
	logic shift_start;
	logic shift_done;
	// Position counter
	logic [AW-1:0] pos_ff;
	logic [AW-1:0] nxt_pos;
	logic pos_last;
	// Pending request
	logic take;
	logic pend_ff;
	logic nxt_pend;
	logic wr_ff;
	logic [AW-1:0] addr_ff;
	logic wdata_ff;
	logic hit;
	logic hit_ff;
	// Link drive
	logic data_in_ff;
	logic recirc_ff;
	logic nxt_recirc;
	// Results
	logic done_ff;
	logic nxt_done;
	logic rdata_ff;
	logic nxt_rdata;

	// Idle leg sets the rate: below the max, far above the min
	assign shift_start = (gap_ff >= CW'(IDLE_END));
	assign shift_done = (state_ff == SSR_PH1);

	always_comb begin
		nxt_state = state_ff;
		nxt_gap = gap_ff;
		case (state_ff)
			SSR_IDLE: begin
				// Free-running keeps the dynamic line alive
				nxt_gap = gap_ff + CW'(1);
				if (shift_start) begin
					nxt_state = SSR_PH2;
					nxt_gap = '0;
				end
			end
			SSR_PH2: begin
				nxt_state = SSR_GAP;
			end
			SSR_GAP: begin
				// Dead cycle keeps the two phases apart
				nxt_state = SSR_PH1;
			end
			SSR_PH1: begin
				nxt_state = SSR_IDLE;
			end
			default: begin
				nxt_state = SSR_IDLE;
				nxt_gap = '0;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			state_ff <= SSR_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			gap_ff <= '0;
		end else begin
			gap_ff <= nxt_gap;
		end
	end

	// Phase pulses straight from the one-hot state bits
	assign link.phase2 = (state_ff == SSR_PH2);
	assign link.phase1 = shift_done;

	// Position counter compared against target
	assign pos_last = (pos_ff == AW'(LINE_BITS - 1));
	assign nxt_pos = pos_last ? '0 : pos_ff + AW'(1);
	assign hit = pend_ff && (pos_ff == addr_ff);

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			pos_ff <= '0;
		end else if (shift_done) begin
			pos_ff <= nxt_pos;
		end
	end

	// One request at a time; a new one is ignored while busy
	assign take = i_req && !pend_ff;

	always_comb begin
		nxt_pend = pend_ff;
		if (take) begin
			nxt_pend = 1'b1;
		end
		if (shift_done && hit_ff) begin
			nxt_pend = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			pend_ff <= 1'b0;
		end else begin
			pend_ff <= nxt_pend;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			wr_ff <= 1'b0;
			addr_ff <= '0;
			wdata_ff <= 1'b0;
		end else if (take) begin
			wr_ff <= i_wr;
			addr_ff <= i_addr;
			wdata_ff <= i_wdata;
		end
	end

	// Hit frozen with the link bits so one shift sees one decision
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			hit_ff <= 1'b0;
		end else if (state_ff == SSR_IDLE) begin
			hit_ff <= hit;
		end
	end

	// Link bits move in idle only, so they stand through phase two
	assign nxt_recirc = !(hit && wr_ff);

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			recirc_ff <= 1'b1;
		end else if (state_ff == SSR_IDLE) begin
			recirc_ff <= nxt_recirc;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			data_in_ff <= 1'b0;
		end else if (state_ff == SSR_IDLE) begin
			data_in_ff <= wdata_ff;
		end
	end

	assign link.recirc = recirc_ff;
	assign link.data_in = data_in_ff;

	// Read takes the line output while it is valid in phase two
	assign nxt_rdata = wr_ff ? wdata_ff : link.data_out;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			rdata_ff <= 1'b0;
		end else if (state_ff == SSR_PH2 && hit_ff) begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign nxt_done = shift_done && hit_ff;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			done_ff <= 1'b0;
		end else begin
			done_ff <= nxt_done;
		end
	end

	assign o_busy = pend_ff;
	assign o_done = done_ff;
	assign o_rdata = rdata_ff;
	assign o_pos = pos_ff;
endmodule : ssr_ctl

/* src/ssr_line.sv */
`timescale 1ns/1ps
`include "ssr_cfg.svh"
module ssr_line
	import ssr_pkg::*;
#(
	parameter int LINE_BITS = `SSR_LINE_BITS
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// Link
	ssr_if.dev link
);
	// No reset of contents: storage is like the dynamic cells
	logic [LINE_BITS-1:0] mstr_ff;
	logic [LINE_BITS-1:0] slv_ff;
	logic out_ff;
	logic in_n;

	// Inverted at entry, inverted again at output
	assign in_n = link.recirc ? !out_ff : !link.data_in;

	genvar g;
	generate
		for (g = 0; g < LINE_BITS; g++) begin : g_stage
			// Split by generate so no stage names a bit below zero
			if (g == 0) begin : g_head
				always_ff @(posedge i_clk_sys) begin
					if (link.phase2) begin
						mstr_ff[g] <= in_n;
					end
				end
			end else begin : g_body
				always_ff @(posedge i_clk_sys) begin
					if (link.phase2) begin
						mstr_ff[g] <= slv_ff[g-1];
					end
				end
			end
			always_ff @(posedge i_clk_sys) begin
				if (link.phase1) begin
					slv_ff[g] <= mstr_ff[g];
				end
			end
		end
	endgenerate

	// Output changes only in phase one
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			out_ff <= 1'b0;
		end else if (link.phase1) begin
			out_ff <= !mstr_ff[LINE_BITS-1];
		end
	end

	assign link.data_out = out_ff;
endmodule : ssr_line

/* bench/ssr_monitor.sv */
`timescale 1ns/1ps
`include "ssr_cfg.svh"
module ssr_monitor #(
	parameter int LINE_BITS = `SSR_LINE_BITS,
	parameter int MAX_GAP = `SSR_MAX_GAP_CYC
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// Link wires
	input wire logic phase1,
	input wire logic phase2,
	input wire logic data_in,
	input wire logic recirc,
	input wire logic data_out
);
	logic [LINE_BITS-1:0] sh_ff;
	logic [LINE_BITS-1:0] vld_ff;
	logic vld_in;
	int fill_ff;
	int gap_ff;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	// Shadow line; bits unwritten stay unchecked
	assign vld_in = recirc ? vld_ff[LINE_BITS-1] : 1'b1;
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			fill_ff <= 0;
			vld_ff <= '0;
		end else if (phase2) begin
			sh_ff <= {sh_ff[LINE_BITS-2:0], recirc ? data_out : data_in};
			vld_ff <= {vld_ff[LINE_BITS-2:0], vld_in};
			fill_ff <= fill_ff + 1;
		end
	end
	always_ff @(posedge i_clk_sys) begin
		gap_ff <= (i_sys_rst || phase1) ? 0 : gap_ff + 1;
	end
	sequence s_pass;
		!phase2 ##1 phase1;
	endsequence
	a_phase_order: assert property (phase2 |=> s_pass)
		else $error("order");
	a_ph_apart: assert property (!(phase1 && phase2))
		else $error("overlap");
	a_pass_after: assert property (phase1 |-> $past(phase2, 2))
		else $error("pass");
	a_out_steady: assert property (!$past(phase1) && !$past(i_sys_rst)
		|-> $stable(data_out)) else $error("out moved");
	a_din_held: assert property (phase2 |=>
		($stable(data_in) && $stable(recirc)) [*2]) else $error("din");
	a_keep_rate: assert property (gap_ff < MAX_GAP)
		else $error("slow");
	a_no_fast: assert property (phase1 |=> !phase1 [*8] ##1 !phase1)
		else $error("fast");
	a_line_len: assert property (phase1 && fill_ff >= LINE_BITS
		&& vld_ff[LINE_BITS-1]
		|=> data_out == $past(sh_ff[LINE_BITS-1])) else $error("line");
endmodule : ssr_monitor

/* bench/serial_shift_register_memory_tb.sv */
`timescale 1ns/1ps
module serial_shift_register_memory_tb;
	localparam int LB = 16;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic req = 1'b0;
	logic wr = 1'b0;
	logic [3:0] addr = 4'h0;
	logic wd = 1'b0;
	logic busy, done, rdata;
	logic [3:0] pos;
	int err_total = 0;
	int checked = 0;
	// Row: write, address, data, expected bit
	logic [6:0] rows [8] = '{7'h43, 7'h7c, 7'h5f, 7'h3c, 7'h01, 7'h1d,
		7'h40, 7'h00};
	ssr_if link();
	ssr_line #(.LINE_BITS(LB)) i_ssr_line (.i_clk_sys(clk),
		.i_sys_rst(rst), .link(link));
	ssr_ctl #(.LINE_BITS(LB)) i_ssr_ctl (.i_clk_sys(clk), .i_sys_rst(rst),
		.i_req(req), .i_wr(wr), .i_addr(addr), .i_wdata(wd), .o_busy(busy),
		.o_done(done), .o_rdata(rdata), .o_pos(pos), .link(link));
	ssr_monitor #(.LINE_BITS(LB)) i_ssr_monitor (.i_clk_sys(clk),
		.i_sys_rst(rst), .phase1(link.phase1), .phase2(link.phase2),
		.data_in(link.data_in), .recirc(link.recirc),
		.data_out(link.data_out));
	always #50 clk = ~clk;
	task automatic cmp(input logic g, input logic e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : cmp
	task automatic op(input logic w, input logic [3:0] a, input logic d);
		int n;
		n = 0;
		req = 1'b1;
		wr = w;
		addr = a;
		wd = d;
		@(negedge clk);
		req = 1'b0;
		cmp(busy, 1'b1);
		while (done !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		cmp(done, 1'b1);
	endtask : op
	task automatic finish_test();
		if (err_total == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (12) @(negedge clk);
		rst = 1'b0;
		foreach (rows[i]) begin
			op(rows[i][6], rows[i][5:2], rows[i][1]);
			cmp(rdata, rows[i][0]);
		end
		for (int i = 0; i < LB; i++) begin
			op(1'b1, i[3:0], i[0] ^ i[2]);
		end
		// Idle passes: contents must survive recirculation
		repeat (LB * 30) @(negedge clk);
		for (int i = 0; i < LB; i++) begin
			op(1'b0, i[3:0], 1'b0);
			cmp(rdata, i[0] ^ i[2]);
		end
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		cmp(busy, 1'b0);
		cmp(pos == 4'h0, 1'b1);
		cmp(link.recirc, 1'b1);
		cmp(link.data_out, 1'b0);
		// Line must still work after a reset in mid-run
		op(1'b1, 4'h3, 1'b1);
		cmp(rdata, 1'b1);
		op(1'b0, 4'h3, 1'b0);
		cmp(rdata, 1'b1);
		finish_test();
	end
	initial begin
		#(100 * 40000);
		err_total++;
		finish_test();
	end
endmodule : serial_shift_register_memory_tb
